// File: core/nvsc_pkg.sv
package nvsc_pkg;
	// ******************************************************************
	// Array geometry and sequence addresses.
	// ******************************************************************
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int SEQ_CMP_W = 14;
	localparam int SEQ_LEN = 6;
	localparam logic [14:0] SEQ_A1 = 15'h0e38;
	localparam logic [14:0] SEQ_A2 = 15'h31c7;
	localparam logic [14:0] SEQ_A3 = 15'h03e0;
	localparam logic [14:0] SEQ_A4 = 15'h3c1f;
	localparam logic [14:0] SEQ_A5 = 15'h303f;
	localparam logic [14:0] SEQ_STORE = 15'h0fc0;
	localparam logic [14:0] SEQ_RECALL = 15'h0c63;
	localparam logic [14:0] SEQ_AS_OFF = 15'h03f8;
	localparam logic [14:0] SEQ_AS_ON = 15'h07f0;

	// ******************************************************************
	// Command codes on the user side.
	// ******************************************************************
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_STORE = 3'h2;
	localparam logic [2:0] CMD_RECALL = 3'h3;
	localparam logic [2:0] CMD_AS_OFF = 3'h4;
	localparam logic [2:0] CMD_AS_ON = 3'h5;
	localparam logic [2:0] CMD_HW_STORE = 3'h6;

	// ******************************************************************
	// Timing at a 25 ns clock.
	// ******************************************************************
	localparam int CLK_NS = 25;
	localparam int CYC_NS = 50;
	localparam int CYC_CLKS = (CYC_NS + CLK_NS - 1) / CLK_NS;
	localparam int DELAY_US = 70;
	localparam int DELAY_CLKS = (DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STORE_US = 15000;
	localparam int STORE_CLKS = (STORE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 20;

	typedef enum logic [5:0] {
		NVSC_IDLE = 6'h01,
		NVSC_SETUP = 6'h02,
		NVSC_STROBE = 6'h04,
		NVSC_RELEASE = 6'h08,
		NVSC_HSB_LOW = 6'h10,
		NVSC_BUSY = 6'h20
	} nvsc_state_e;
endpackage

// File: core/nvsc_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Gate held high during writes.
// - Store sequence: five leaders then 0x0FC0.
// - Recall sequence: five leaders then 0x0C63.
// - Sequence cycles are reads, strobe high.
module nvsc_host #(
	parameter int STORE_CYCLES = nvsc_pkg::STORE_CLKS,
	parameter int DELAY_CYCLES = nvsc_pkg::DELAY_CLKS,
	parameter int STROBE_CYCLES = nvsc_pkg::CYC_CLKS
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire logic [2:0] cmd_code_in,
	input wire logic [nvsc_pkg::ADDR_W-1:0] cmd_addr_in,
	input wire logic [nvsc_pkg::DATA_W-1:0] cmd_wdata_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata_out,
	output logic [nvsc_pkg::ADDR_W-1:0] address_bus_out,
	output logic [nvsc_pkg::DATA_W-1:0] data_bus_out,
	output logic data_bus_oe_out,
	input wire logic [nvsc_pkg::DATA_W-1:0] data_bus_in,
	output logic chip_select_n_out,
	output logic write_strobe_n_out,
	output logic output_gate_n_out,
	output logic store_busy_n_out,
	output logic store_busy_oe_out,
	input wire logic store_busy_n_in
);
	// ******************************************************************
	// Pin synchronisers.
	// ******************************************************************
	logic busy_meta;
	logic busy_sync;
	logic [nvsc_pkg::DATA_W-1:0] data_meta;
	logic [nvsc_pkg::DATA_W-1:0] data_sync;

	// Both pins come from the device's asynchronous logic, so two flops each.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			busy_meta <= 1'b1;
			busy_sync <= 1'b1;
			data_meta <= '0;
			data_sync <= '0;
		end else begin
			busy_meta <= store_busy_n_in;
			busy_sync <= busy_meta;
			data_meta <= data_bus_in;
			data_sync <= data_meta;
		end
	end

	// ******************************************************************
	// Cycle sequencer.
	// ******************************************************************
	nvsc_pkg::nvsc_state_e state;
	nvsc_pkg::nvsc_state_e next_state;
	logic [nvsc_pkg::CNT_W-1:0] cnt;
	logic [nvsc_pkg::CNT_W-1:0] next_cnt;
	logic [2:0] step;
	logic [2:0] next_step;
	logic [2:0] code;
	logic [2:0] next_code;
	logic [nvsc_pkg::ADDR_W-1:0] addr;
	logic [nvsc_pkg::ADDR_W-1:0] next_addr;
	logic [nvsc_pkg::DATA_W-1:0] wdata;
	logic [nvsc_pkg::DATA_W-1:0] next_wdata;
	logic [nvsc_pkg::DATA_W-1:0] rdata;
	logic [nvsc_pkg::DATA_W-1:0] next_rdata;
	logic next_rsp;
	logic is_seq;
	logic is_write;
	logic [nvsc_pkg::ADDR_W-1:0] seq_addr;

	assign is_seq = (code == nvsc_pkg::CMD_STORE) || (code == nvsc_pkg::CMD_RECALL) ||
		(code == nvsc_pkg::CMD_AS_OFF) || (code == nvsc_pkg::CMD_AS_ON);
	assign is_write = (code == nvsc_pkg::CMD_WRITE);

	// Address of the current sequence step; the top bit is kept low since the device ignores it.
	always_comb begin
		unique case (step)
			3'h0: seq_addr = nvsc_pkg::SEQ_A1;
			3'h1: seq_addr = nvsc_pkg::SEQ_A2;
			3'h2: seq_addr = nvsc_pkg::SEQ_A3;
			3'h3: seq_addr = nvsc_pkg::SEQ_A4;
			3'h4: seq_addr = nvsc_pkg::SEQ_A5;
			default: begin
				if (code == nvsc_pkg::CMD_STORE) begin
					seq_addr = nvsc_pkg::SEQ_STORE;
				end else if (code == nvsc_pkg::CMD_RECALL) begin
					seq_addr = nvsc_pkg::SEQ_RECALL;
				end else if (code == nvsc_pkg::CMD_AS_OFF) begin
					seq_addr = nvsc_pkg::SEQ_AS_OFF;
				end else begin
					seq_addr = nvsc_pkg::SEQ_AS_ON;
				end
			end
		endcase
	end

	// Next-state logic: one strobed cycle per access, six for a sequence.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_step = step;
		next_code = code;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		next_rsp = 1'b0;
		unique case (state)
			nvsc_pkg::NVSC_IDLE: begin
				// New work waits while busy is low: no access may be started then.
				if (cmd_valid_in && busy_sync) begin
					next_code = cmd_code_in;
					next_addr = cmd_addr_in;
					next_wdata = cmd_wdata_in;
					next_step = 3'h0;
					next_cnt = '0;
					if (cmd_code_in == nvsc_pkg::CMD_HW_STORE) begin
						next_state = nvsc_pkg::NVSC_HSB_LOW;
					end else begin
						next_state = nvsc_pkg::NVSC_SETUP;
					end
				end
			end
			nvsc_pkg::NVSC_SETUP: begin
				// Address settles one cycle before select falls only for reads and writes after a non-sequence command.
				if (is_seq) begin
					next_addr = seq_addr;
				end
				next_cnt = '0;
				next_state = nvsc_pkg::NVSC_STROBE;
			end
			nvsc_pkg::NVSC_STROBE: begin
				next_cnt = cnt + 1'b1;
				if (cnt == nvsc_pkg::CNT_W'(STROBE_CYCLES)) begin
					next_rdata = data_sync;
					next_state = nvsc_pkg::NVSC_RELEASE;
				end
			end
			nvsc_pkg::NVSC_RELEASE: begin
				next_cnt = '0;
				if (is_seq && step != 3'(nvsc_pkg::SEQ_LEN - 1)) begin
					next_step = step + 1'b1;
					next_state = nvsc_pkg::NVSC_SETUP;
				end else if (code == nvsc_pkg::CMD_STORE || code == nvsc_pkg::CMD_RECALL) begin
					next_state = nvsc_pkg::NVSC_BUSY;
				end else begin
					next_rsp = 1'b1;
					next_state = nvsc_pkg::NVSC_IDLE;
				end
			end
			nvsc_pkg::NVSC_HSB_LOW: begin
				// Hold the request for the settle window, then let the device own the pin.
				next_cnt = cnt + 1'b1;
				if (cnt == nvsc_pkg::CNT_W'(DELAY_CYCLES)) begin
					next_cnt = '0;
					next_state = nvsc_pkg::NVSC_BUSY;
				end
			end
			nvsc_pkg::NVSC_BUSY: begin
				// A skipped store shows busy high after the window; a recall never shows busy, so it waits in full.
				next_cnt = cnt + 1'b1;
				if (cnt == nvsc_pkg::CNT_W'(STORE_CYCLES) || (code != nvsc_pkg::CMD_RECALL && busy_sync &&
					cnt > nvsc_pkg::CNT_W'(DELAY_CYCLES))) begin
					next_rsp = 1'b1;
					next_state = nvsc_pkg::NVSC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state <= nvsc_pkg::NVSC_IDLE;
			cnt <= '0;
			step <= 3'h0;
			code <= nvsc_pkg::CMD_READ;
			addr <= '0;
			wdata <= '0;
			rdata <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			step <= next_step;
			code <= next_code;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
		end
	end

	// ******************************************************************
	// Pin drivers, all registered.
	// ******************************************************************
	logic [nvsc_pkg::CNT_W-1:0] hsb_run;
	// Select is released between every cycle so each read gives a fresh falling edge.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			address_bus_out <= '0;
			data_bus_out <= '0;
			data_bus_oe_out <= 1'b0;
			chip_select_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			output_gate_n_out <= 1'b1;
			store_busy_n_out <= 1'b0;
			store_busy_oe_out <= 1'b0;
			cmd_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
			hsb_run <= '0;
		end else begin
			address_bus_out <= (next_state == nvsc_pkg::NVSC_SETUP && is_seq) ? seq_addr : next_addr;
			data_bus_out <= next_wdata;
			data_bus_oe_out <= (next_state == nvsc_pkg::NVSC_STROBE) && is_write;
			chip_select_n_out <= !(next_state == nvsc_pkg::NVSC_STROBE);
			write_strobe_n_out <= !((next_state == nvsc_pkg::NVSC_STROBE) && is_write);
			output_gate_n_out <= !((next_state == nvsc_pkg::NVSC_STROBE) && !is_write);
			store_busy_n_out <= 1'b0;
			store_busy_oe_out <= (next_state == nvsc_pkg::NVSC_HSB_LOW);
			cmd_ready_out <= (next_state == nvsc_pkg::NVSC_IDLE) && busy_meta && busy_sync;
			rsp_valid_out <= next_rsp;
			rsp_rdata_out <= next_rdata;
			hsb_run <= store_busy_oe_out ? hsb_run + 1'b1 : '0; // Length of our pull, checked below.
		end
	end

	// ******************************************************************
	// Checks.
	// ******************************************************************
	property p_gate_write_excl;
		@(posedge clock_in) disable iff (rst_in) !write_strobe_n_out |-> output_gate_n_out;
	endproperty
	a_gate_write_excl: assert property (p_gate_write_excl) else $error("gate low during write");

	property p_seq_no_write;
		@(posedge clock_in) disable iff (rst_in) (is_seq && !chip_select_n_out) |-> write_strobe_n_out;
	endproperty
	a_seq_no_write: assert property (p_seq_no_write) else $error("write in mode sequence");

	property p_top_bit_low;
		@(posedge clock_in) disable iff (rst_in) (is_seq && !chip_select_n_out) |-> !address_bus_out[14];
	endproperty
	a_top_bit_low: assert property (p_top_bit_low) else $error("sequence top bit set");

	property p_no_access_busy;
		@(posedge clock_in) disable iff (rst_in) (state == nvsc_pkg::NVSC_BUSY) |-> chip_select_n_out;
	endproperty
	a_no_access_busy: assert property (p_no_access_busy) else $error("access during store");

	property p_select_pulse;
		@(posedge clock_in) disable iff (rst_in) $fell(chip_select_n_out) |-> !chip_select_n_out[*2] ##1 1'b1;
	endproperty
	a_select_pulse: assert property (p_select_pulse) else $error("select pulse too short");

	property p_hsb_release;
		@(posedge clock_in) disable iff (rst_in) store_busy_oe_out |-> (hsb_run <= nvsc_pkg::CNT_W'(DELAY_CYCLES));
	endproperty
	a_hsb_release: assert property (p_hsb_release) else $error("busy request held too long");

	property p_write_data_driven;
		@(posedge clock_in) disable iff (rst_in) !write_strobe_n_out |-> data_bus_oe_out && !chip_select_n_out;
	endproperty
	a_write_data_driven: assert property (p_write_data_driven) else $error("write without data");

	property p_read_gate;
		@(posedge clock_in) disable iff (rst_in) !output_gate_n_out |-> !chip_select_n_out && !data_bus_oe_out;
	endproperty
	a_read_gate: assert property (p_read_gate) else $error("gate without select");

	c_write: cover property (@(posedge clock_in) disable iff (rst_in) $rose(write_strobe_n_out));
	c_seq_done: cover property (@(posedge clock_in) disable iff (rst_in)
		state == nvsc_pkg::NVSC_RELEASE && step == 3'h5);
	c_hw_store: cover property (@(posedge clock_in) disable iff (rst_in) $fell(store_busy_oe_out));
endmodule

// File: bench/nvsc_dev.sv
`timescale 1ns/1ps
// ******************************************************************
// Behavioural memory device on the far side of the host pins.
// ******************************************************************
module nvsc_dev #(
	parameter int SETTLE = 10,
	parameter int BUSY = 60
) (
	input wire logic clock_in,
	input wire logic [14:0] address_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_out,
	input wire logic chip_select_n_in,
	input wire logic write_strobe_n_in,
	input wire logic output_gate_n_in,
	input wire logic store_busy_n_in,
	input wire logic supply_low_in,
	output logic busy_drive_out
);
	logic [7:0] sram [0:32767];
	logic [7:0] nv [0:32767];
	logic [13:0] lead [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
	logic [7:0] last = 8'h00;
	logic p_cs = 1'b1, p_we = 1'b1, p_busy = 1'b1, p_low = 1'b0, arm = 1'b1, dirty = 1'b0, storing = 1'b0;
	logic auto_en = 1'b1;
	logic [14:0] p_a = 15'h0000;
	logic [7:0] p_d = 8'h00;
	int step = 0, lock = 0, settle = 0;
	// A released bus shows the inverse of the last byte so a stale value never looks valid.
	assign data_oe_out = !chip_select_n_in && !output_gate_n_in && write_strobe_n_in && store_busy_n_in && lock == 0;
	assign data_out = data_oe_out ? sram[address_in] : ~last;
	assign busy_drive_out = lock > 0 && storing;
	// The store copies every byte and locks the pins; the write mode must be re-entered afterwards.
	task automatic do_store();
		for (int i = 0; i < 32768; i++) nv[i] <= sram[i];
		{storing, dirty, arm} <= 3'b100;
		lock <= BUSY;
	endtask
	// Each select fall with the strobe high and the expected address advances the match; anything else restarts it.
	task automatic seq_step();
		if (!write_strobe_n_in) step <= 0;
		else if (step < 5) step <= address_in[13:0] == lead[step] ? step + 1 : 0;
		else begin
			step <= 0;
			case (address_in[13:0])
				14'h0fc0: do_store();
				14'h03f8: auto_en <= 1'b0;
				14'h07f0: auto_en <= 1'b1;
				14'h0c63: begin
					for (int i = 0; i < 32768; i++) sram[i] <= nv[i];
					{storing, dirty, arm} <= 3'b000;
					lock <= BUSY;
				end
				default: step <= 0;
			endcase
		end
	endtask
	// Pins are sampled on the clock; a write lands when its strobe or select ends.
	always @(posedge clock_in) begin
		if (data_oe_out) last <= data_out;
		if (lock > 0) begin
			lock <= lock - 1;
			if (lock == 1) storing <= 1'b0;
		end else if (supply_low_in && !p_low) begin
			// A supply drop runs one store from the backup capacitor if autostore is enabled and anything changed.
			if (auto_en && dirty) do_store();
		end else if (!p_busy && !store_busy_n_in) begin
			settle <= settle + 1;
			if (settle == SETTLE && dirty && !supply_low_in) do_store();
		end else begin
			settle <= 0;
			if ((p_cs && !chip_select_n_in) || (p_we && !write_strobe_n_in)) arm <= 1'b1;
			if (!p_cs && !p_we && (chip_select_n_in || write_strobe_n_in) && arm && !supply_low_in) begin
				sram[p_a] <= p_d;
				dirty <= 1'b1;
			end
			if (p_cs && !chip_select_n_in) seq_step();
		end
		{p_cs, p_we, p_busy, p_low} <= {chip_select_n_in, write_strobe_n_in, store_busy_n_in, supply_low_in};
		{p_a, p_d} <= {address_in, data_in};
	end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
// ******************************************************************
// Host controller against the behavioural device.
// ******************************************************************
module tb;
	logic clock_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, p_cs = 1'b1, drv_seen = 1'b0, supply_low = 1'b0;
	logic [2:0] cmd_code_in = 3'h0;
	logic [14:0] cmd_addr_in = 15'h0000;
	logic [7:0] cmd_wdata_in = 8'h00, q;
	logic [13:0] lead [0:4] = '{nvsc_pkg::SEQ_A1[13:0], nvsc_pkg::SEQ_A2[13:0], nvsc_pkg::SEQ_A3[13:0],
		nvsc_pkg::SEQ_A4[13:0], nvsc_pkg::SEQ_A5[13:0]};
	wire cmd_ready_out, rsp_valid_out, data_bus_oe_out, chip_select_n_out, write_strobe_n_out, output_gate_n_out;
	wire store_busy_n_out, store_busy_oe_out, dev_oe, dev_drv;
	wire [7:0] rsp_rdata_out, data_bus_out, dev_d;
	wire [14:0] address_bus_out;
	// The busy line has a weak pull-up, so it is low only while someone pulls it.
	wire [7:0] dq = data_bus_oe_out ? data_bus_out : dev_d;
	wire busy_w = !(store_busy_oe_out && !store_busy_n_out) && !dev_drv;
	int failures = 0, total_checks = 0, seed = 16173, pull_n = 0;
	logic [7:0] exp [logic [14:0]];
	logic [7:0] nv [logic [14:0]];
	logic [13:0] log_q [$];
	nvsc_host #(.STORE_CYCLES(200), .DELAY_CYCLES(20)) nvsc_host_inst (.clock_in, .rst_in, .cmd_valid_in,
		.cmd_code_in, .cmd_addr_in, .cmd_wdata_in, .cmd_ready_out, .rsp_valid_out, .rsp_rdata_out,
		.address_bus_out, .data_bus_out, .data_bus_oe_out, .data_bus_in(dq), .chip_select_n_out,
		.write_strobe_n_out, .output_gate_n_out, .store_busy_n_out, .store_busy_oe_out, .store_busy_n_in(busy_w));
	nvsc_dev nvsc_dev_inst (.clock_in, .address_in(address_bus_out), .data_in(dq), .data_out(dev_d),
		.data_oe_out(dev_oe), .chip_select_n_in(chip_select_n_out), .write_strobe_n_in(write_strobe_n_out),
		.output_gate_n_in(output_gate_n_out), .store_busy_n_in(busy_w), .supply_low_in(supply_low),
		.busy_drive_out(dev_drv));
	initial forever #12.5 clock_in = ~clock_in;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", nm, want, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Select falls are logged for sequence checks; the pull-down on busy is timed.
	always @(negedge clock_in) begin
		if (p_cs && !chip_select_n_out) log_q.push_back(address_bus_out[13:0]);
		p_cs = chip_select_n_out;
		if (dev_drv) drv_seen = 1'b1;
		if (store_busy_oe_out && !store_busy_n_out) pull_n++;
		if (!rst_in && !write_strobe_n_out) check("gate in write", output_gate_n_out, 1);
	end
	// One command, waited for under a bound; the hang limit counts as a mismatch.
	task automatic cmd(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(negedge clock_in);
		while (cmd_ready_out !== 1'b1 && n < 20000) begin
			@(negedge clock_in);
			n++;
		end
		{cmd_code_in, cmd_addr_in, cmd_wdata_in, cmd_valid_in} = {c, a, d, 1'b1};
		@(negedge clock_in);
		cmd_valid_in = 1'b0;
		n = (n < 20000) ? 1 : n;
		while (rsp_valid_out !== 1'b1 && n < 20000) begin
			@(negedge clock_in);
			n++;
		end
		if (n >= 20000) begin
			failures++;
			tally_and_finish();
		end
		if (c < 3'h2) check("latency", n, 6);
		r = rsp_rdata_out;
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		cmd(nvsc_pkg::CMD_WRITE, a, d, q);
		exp[a] = d;
	endtask
	task automatic rd(input logic [14:0] a);
		cmd(nvsc_pkg::CMD_READ, a, 8'h00, q);
		check("read data", q, exp[a]);
	endtask
	task automatic seq(input logic [2:0] c, input logic [14:0] fin);
		log_q.delete();
		cmd(c, 15'h0000, 8'h00, q);
		check("seq len", log_q.size(), 6);
		for (int i = 0; i < 6; i++) check("seq addr", log_q[i], i < 5 ? lead[i] : fin[13:0]);
	endtask
	task automatic hw(input logic want);
		{drv_seen, pull_n} = 0;
		cmd(nvsc_pkg::CMD_HW_STORE, 15'h0000, 8'h00, q);
		check("pull cycles", pull_n, 21);
		check("store ran", drv_seen, want);
	endtask
	// Random traffic with corner addresses, then store, recall and mode sequences.
	initial begin
		repeat (16) @(negedge clock_in);
		rst_in = 1'b0;
		check("auto default", nvsc_dev_inst.auto_en, 1);
		for (int i = 0; i < 10; i++) wr(i == 0 ? 15'h0000 : i == 1 ? 15'h7fff : 15'($random(seed)), 8'($random(seed)));
		wr(15'h1234, 8'h5a);
		rd(15'h1234);
		foreach (exp[k]) rd(k);
		drv_seen = 1'b0;
		nv = exp;
		seq(nvsc_pkg::CMD_STORE, nvsc_pkg::SEQ_STORE);
		check("sw store busy", drv_seen, 1);
		wr(15'h0000, ~exp[15'h0000]);
		rd(15'h0000);
		seq(nvsc_pkg::CMD_RECALL, nvsc_pkg::SEQ_RECALL);
		exp = nv;
		rd(15'h0000);
		hw(1'b0);
		wr(15'h0000, 8'h3c);
		hw(1'b1);
		nv = exp;
		wr(15'h0000, 8'hff);
		seq(nvsc_pkg::CMD_RECALL, nvsc_pkg::SEQ_RECALL);
		exp = nv;
		rd(15'h0000);
		seq(nvsc_pkg::CMD_AS_OFF, nvsc_pkg::SEQ_AS_OFF);
		check("auto off", nvsc_dev_inst.auto_en, 0);
		seq(nvsc_pkg::CMD_AS_ON, nvsc_pkg::SEQ_AS_ON);
		check("auto on", nvsc_dev_inst.auto_en, 1);
		// Supply drop after a write: one automatic store, then a write under low supply must not land.
		wr(15'h0002, 8'h77);
		{drv_seen, supply_low} = 2'b01;
		repeat (4) @(negedge clock_in);
		cmd(nvsc_pkg::CMD_WRITE, 15'h0002, 8'h88, q);
		supply_low = 1'b0;
		check("power loss store", drv_seen, 1);
		rd(15'h0002);
		tally_and_finish();
	end
endmodule
